// *** hdl/rpoc_ctrl.sv ***
// Reset and power-on controller: cause merging, power-on sequence, watchdog
`timescale 1ns/1ps

module rpoc_ctrl
	import rpoc_pkg::*;
#(
	parameter int POWER_CYCLES = POWER_STAB_CYCLES,
	parameter int DEBOUNCE_LOW_CYCLES = DEBOUNCE_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic reset_pin_n,
	input wire logic vdd_below_1v8,
	input wire logic vdd_below_2v4,
	input wire logic vdd_below_3v3,
	input wire logic ilrc_clk,
	input wire logic hosc_clk,
	input wire logic [1:0] detect_level,
	input wire logic [1:0] pin_mode,
	input wire logic [1:0] wdt_mode,
	input wire logic [1:0] wdt_prescale,
	input wire logic [2:0] clock_source_cfg,
	input wire logic [1:0] cpu_mode,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	output logic sys_reset_n,
	output logic [15:0] reset_vector,
	output logic osc_enable,
	output logic [2:0] clock_source_sel,
	output logic shared_reset_port_bit
);

	////////////////////////////////////////////////////////////////////////
	// Decoding functions

	function automatic logic [5:0] wdt_divisor(input logic [1:0] sel);
		wdt_divisor = 6'h04 << sel;
	endfunction : wdt_divisor

	function automatic logic lvd_trip(input logic [1:0] lvl, input logic b18,
		input logic b24, input logic b33);
		unique case (lvl)
			DETECT_LEVEL_LOWEST: lvd_trip = b18;
			DETECT_LEVEL_MEDIUM: lvd_trip = b18;
			DETECT_LEVEL_HIGH: lvd_trip = b24;
			default: lvd_trip = b33;
		endcase
	endfunction : lvd_trip

	////////////////////////////////////////////////////////////////////////
	// Input synchronisers

	logic [SYNC_W-1:0] async_in;
	logic [SYNC_W-1:0] sync1;
	logic [SYNC_W-1:0] sync2;
	logic [1:0] osc_prev;

	assign async_in = {reset_pin_n, vdd_below_1v8, vdd_below_2v4, vdd_below_3v3,
		ilrc_clk, hosc_clk};

	genvar gi;
	generate
		for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
			always_ff @(posedge ref_clk or negedge rstn) begin
				if (!rstn) begin
					sync1[gi] <= SYNC_RESET[gi];
					sync2[gi] <= SYNC_RESET[gi];
				end else begin
					sync1[gi] <= async_in[gi];
					sync2[gi] <= sync1[gi];
				end
			end
		end
	endgenerate

	// Edge detection reads only the second stage
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			osc_prev <= 2'h0;
		end else begin
			osc_prev <= sync2[1:0];
		end
	end

	logic pin_high;
	logic below_1v8;
	logic below_2v4;
	logic below_3v3;
	logic ilrc_rise;
	logic hosc_rise;

	assign pin_high = sync2[5];
	assign below_1v8 = sync2[4];
	assign below_2v4 = sync2[3];
	assign below_3v3 = sync2[2];
	assign ilrc_rise = sync2[1] & ~osc_prev[1];
	assign hosc_rise = sync2[0] & ~osc_prev[0];

	////////////////////////////////////////////////////////////////////////
	// Register port decode

	logic wr_cause;
	logic wr_swrst;
	logic wr_wdclr;
	logic wdt_clear;

	assign wr_cause = sfr_wr && (sfr_addr == REG_CAUSE_ADDR);
	assign wr_swrst = sfr_wr && (sfr_addr == REG_SWRST_ADDR);
	assign wr_wdclr = sfr_wr && (sfr_addr == REG_WDCLR_ADDR);
	assign wdt_clear = wr_wdclr && (sfr_wdata == WDT_CLEAR_KEY);

	////////////////////////////////////////////////////////////////////////
	// Voltage detection

	logic lvd_reset;
	logic next_mid_low;
	logic next_high_low;
	logic mid_voltage_low_flag;
	logic high_voltage_low_flag;

	assign lvd_reset = lvd_trip(detect_level, below_1v8, below_2v4, below_3v3);
	assign next_mid_low = (detect_level == DETECT_LEVEL_MEDIUM) && below_2v4;
	assign next_high_low = (detect_level == DETECT_LEVEL_HIGH) && below_3v3;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			mid_voltage_low_flag <= 1'b0;
			high_voltage_low_flag <= 1'b0;
		end else begin
			mid_voltage_low_flag <= next_mid_low;
			high_voltage_low_flag <= next_high_low;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Shared reset pin

	localparam logic [23:0] DEB_LAST = 24'(DEBOUNCE_LOW_CYCLES);

	logic [23:0] deb_cnt;
	logic deb_mode;
	logic direct_mode;
	logic pin_reset;

	assign deb_mode = (pin_mode == PIN_RESET_DEBOUNCE);
	assign direct_mode = (pin_mode == PIN_RESET_DIRECT);

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			deb_cnt <= 24'h000000;
		end else if (pin_high || !deb_mode) begin
			deb_cnt <= 24'h000000;
		end else if (deb_cnt != DEB_LAST) begin
			deb_cnt <= deb_cnt + 24'h000001;
		end
	end

	assign pin_reset = (direct_mode && !pin_high) || (deb_mode && deb_cnt == DEB_LAST);

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			shared_reset_port_bit <= 1'b0;
		end else begin
			shared_reset_port_bit <= !deb_mode && !direct_mode && pin_high;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Watchdog

	rpoc_state_t state;
	rpoc_state_t next_state;
	logic [5:0] pre_cnt;
	logic [7:0] wdt_cnt;
	logic [5:0] pre_last;
	logic wdt_run;
	logic wdt_tick;
	logic wdt_fire;

	assign pre_last = wdt_divisor(wdt_prescale) - 6'h01;
	assign wdt_run = (state == ST_RUN) && ((wdt_mode == WDT_MODE_ALWAYS)
		|| (wdt_mode == WDT_MODE_ENABLE && cpu_mode == CPU_NORMAL));
	assign wdt_tick = wdt_run && ilrc_rise && (pre_cnt == pre_last) && !wdt_clear;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pre_cnt <= 6'h00;
		end else if (state != ST_RUN || wdt_clear) begin
			pre_cnt <= 6'h00;
		end else if (wdt_run && ilrc_rise) begin
			pre_cnt <= (pre_cnt == pre_last) ? 6'h00 : pre_cnt + 6'h01;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			wdt_cnt <= 8'h00;
		end else if (state != ST_RUN || wdt_clear) begin
			wdt_cnt <= 8'h00;
		end else if (wdt_tick) begin
			wdt_cnt <= wdt_cnt + 8'h01;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			wdt_fire <= 1'b0;
		end else begin
			wdt_fire <= wdt_tick && (wdt_cnt == 8'(WDT_OVERFLOW_TICKS - 1));
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Software reset request

	logic sw_armed;
	logic sw_fire;
	logic sw_set;

	assign sw_set = wr_swrst && sfr_wdata[SWRST_BIT];
	assign sw_fire = sw_set && sw_armed && (state == ST_RUN);

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			sw_armed <= 1'b0;
		end else if (state != ST_RUN || sw_fire) begin
			sw_armed <= 1'b0;
		end else if (sfr_wr) begin
			sw_armed <= sw_set;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Reset sequencer

	localparam logic [23:0] POWER_LAST = 24'(POWER_CYCLES - 1);
	localparam logic [23:0] HOSC_LAST = 24'(HOSC_WARMUP_PERIODS - 1);
	localparam logic [23:0] ILRC_LAST = 24'(ILRC_WARMUP_PERIODS - 1);
	localparam logic [23:0] SOFT_LAST = 24'(SW_HOLD_CYCLES - 1);

	logic [23:0] stage_cnt;
	logic [23:0] stage_last;
	logic stage_event;
	logic stage_done;
	logic hw_level;
	logic hw_cause;

	assign hw_level = lvd_reset || pin_reset;
	assign hw_cause = hw_level || wdt_fire;

	assign stage_event = (state == ST_POWER) || (state == ST_SOFT)
		|| (state == ST_HOSC && hosc_rise) || (state == ST_ILRC && ilrc_rise);
	assign stage_last = (state == ST_POWER) ? POWER_LAST :
		(state == ST_HOSC) ? HOSC_LAST :
		(state == ST_ILRC) ? ILRC_LAST : SOFT_LAST;
	assign stage_done = stage_event && (stage_cnt == stage_last);

	always_comb begin
		next_state = state;
		unique case (state)
			ST_HOLD: if (!hw_level) next_state = ST_POWER;
			ST_POWER: if (stage_done) next_state = ST_HOSC;
			ST_HOSC: if (stage_done) next_state = ST_ILRC;
			ST_ILRC: if (stage_done) next_state = ST_RUN;
			ST_SOFT: if (stage_done) next_state = ST_RUN;
			ST_RUN: if (sw_fire) next_state = ST_SOFT;
		endcase
		if (hw_cause) begin
			next_state = ST_HOLD;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			state <= ST_POWER;
		end else begin
			state <= next_state;
		end
	end

	// Counter restarts on every stage change
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			stage_cnt <= 24'h000000;
		end else if (next_state != state) begin
			stage_cnt <= 24'h000000;
		end else if (stage_event) begin
			stage_cnt <= stage_cnt + 24'h000001;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			sys_reset_n <= 1'b0;
			reset_vector <= RESET_VECTOR;
		end else begin
			sys_reset_n <= (next_state == ST_RUN);
			reset_vector <= RESET_VECTOR;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			osc_enable <= 1'b0;
			clock_source_sel <= 3'h0;
		end else begin
			osc_enable <= (next_state != ST_HOLD) && (next_state != ST_POWER);
			if (state == ST_POWER && next_state == ST_HOSC) begin
				clock_source_sel <= clock_source_cfg;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Cause flags and read port

	logic [2:0] cause_flags;
	logic [2:0] new_cause;
	logic fresh_cause;

	assign new_cause = {lvd_reset, wdt_fire, pin_reset};
	// A cause in run or software reset replaces the old record; during hardware reset they merge
	assign fresh_cause = hw_cause && (state == ST_RUN || state == ST_SOFT);

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			cause_flags <= 3'h0;
		end else if (fresh_cause) begin
			cause_flags <= new_cause;
		end else begin
			cause_flags <= cause_flags | new_cause;
		end
	end

	logic [7:0] cause_word;
	logic [7:0] swrst_word;
	logic [7:0] read_word;

	always_comb begin
		cause_word = REG_RESET_VALUE;
		cause_word[CAUSE_LVD_BIT] = cause_flags[2];
		cause_word[CAUSE_WDT_BIT] = cause_flags[1];
		cause_word[CAUSE_PIN_BIT] = cause_flags[0];
		cause_word[MID_LOW_BIT] = mid_voltage_low_flag;
		cause_word[HIGH_LOW_BIT] = high_voltage_low_flag;
		swrst_word = REG_RESET_VALUE;
		swrst_word[SWRST_BIT] = sw_armed;
	end

	// Clear register and unmapped addresses read as zero
	assign read_word = (sfr_addr == REG_CAUSE_ADDR) ? cause_word :
		(sfr_addr == REG_SWRST_ADDR) ? swrst_word : REG_RESET_VALUE;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			sfr_rdata <= REG_RESET_VALUE;
		end else if (sfr_rd) begin
			sfr_rdata <= read_word;
		end
	end

	// Writes to the read-only cause register have no effect
	logic unused_wr;
	assign unused_wr = wr_cause;

endmodule : rpoc_ctrl

// *** hdl/rpoc_pkg.sv ***
// Constants, encodings and types of the reset and power-on controller
package rpoc_pkg;

	// Register addresses on the special function register port
	localparam logic [7:0] REG_CAUSE_ADDR = 8'hf8;
	localparam logic [7:0] REG_SWRST_ADDR = 8'hf7;
	localparam logic [7:0] REG_WDCLR_ADDR = 8'h86;

	// Field positions of reset_cause_flags
	localparam int CAUSE_LVD_BIT = 7;
	localparam int CAUSE_WDT_BIT = 6;
	localparam int CAUSE_PIN_BIT = 5;
	localparam int MID_LOW_BIT = 2;
	localparam int HIGH_LOW_BIT = 1;
	// Field position of software_reset_request_bit
	localparam int SWRST_BIT = 0;

	localparam logic [7:0] WDT_CLEAR_KEY = 8'h5a;
	localparam logic [7:0] REG_RESET_VALUE = 8'h00;
	localparam logic [15:0] RESET_VECTOR = 16'h0000;

	// Detect level option codes
	localparam logic [1:0] DETECT_LEVEL_LOWEST = 2'h0;
	localparam logic [1:0] DETECT_LEVEL_MEDIUM = 2'h1;
	localparam logic [1:0] DETECT_LEVEL_HIGH = 2'h2;
	localparam logic [1:0] DETECT_LEVEL_MAXIMUM = 2'h3;

	// Shared pin option codes; the unused code acts as port bit
	localparam logic [1:0] PIN_RESET_DEBOUNCE = 2'h0;
	localparam logic [1:0] PIN_RESET_DIRECT = 2'h1;
	localparam logic [1:0] PIN_PORT_BIT = 2'h2;

	// Watchdog option codes; the unused code acts as disabled
	localparam logic [1:0] WDT_MODE_ALWAYS = 2'h0;
	localparam logic [1:0] WDT_MODE_ENABLE = 2'h1;
	localparam logic [1:0] WDT_MODE_DISABLE = 2'h2;

	// CPU operating mode codes
	localparam logic [1:0] CPU_NORMAL = 2'h0;
	localparam logic [1:0] CPU_IDLE = 2'h1;
	localparam logic [1:0] CPU_STOP = 2'h2;

	// Counts and times
	localparam int WDT_OVERFLOW_TICKS = 256;
	localparam int HOSC_WARMUP_PERIODS = 2048;
	localparam int ILRC_WARMUP_PERIODS = 5;
	localparam int SW_HOLD_CYCLES = 4;
	localparam int REF_CLK_MHZ = 200;
	localparam int POWER_STAB_US = 4600;
	localparam int DEBOUNCE_US = 8000;
	localparam int POWER_STAB_CYCLES = POWER_STAB_US * REF_CLK_MHZ;
	localparam int DEBOUNCE_CYCLES = DEBOUNCE_US * REF_CLK_MHZ;

	// Synchronised inputs: pin, 1.8, 2.4, 3.3 detectors, slow osc, fast osc
	localparam int SYNC_W = 6;
	localparam logic [SYNC_W-1:0] SYNC_RESET = 6'h20;

	typedef enum logic [2:0] {
		ST_HOLD, ST_POWER, ST_HOSC, ST_ILRC, ST_SOFT, ST_RUN
	} rpoc_state_t;

endpackage : rpoc_pkg

// *** verif/rpoc_ctrl_properties.sv ***
// Port checker of the reset and power-on controller
`timescale 1ns/1ps
module rpoc_ctrl_checker
	import rpoc_pkg::*;
#(
	parameter int POWER_CYCLES = POWER_STAB_CYCLES,
	parameter int DEBOUNCE_LOW_CYCLES = DEBOUNCE_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic reset_pin_n,
	input wire logic vdd_below_2v4,
	input wire logic hosc_clk,
	input wire logic [1:0] detect_level,
	input wire logic [1:0] pin_mode,
	input wire logic [2:0] clock_source_cfg,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic [7:0] sfr_rdata,
	input wire logic sys_reset_n,
	input wire logic [15:0] reset_vector,
	input wire logic osc_enable,
	input wire logic [2:0] clock_source_sel
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	////////////////////////////////////////////////////////////////////////
	logic armed;
	logic hosc_q;
	int pcnt;
	int hcnt;
	wire logic soft_hit = sfr_wr && sfr_addr == REG_SWRST_ADDR && sfr_wdata[SWRST_BIT];
	wire logic soft_req = soft_hit && armed && sys_reset_n;
	// Raw fast-clock rises; the design sees them later, so this count leads
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			armed <= 1'b0;
			hosc_q <= 1'b0;
			pcnt <= 0;
			hcnt <= 0;
		end else begin
			armed <= !sys_reset_n ? 1'b0 : (sfr_wr ? soft_hit : armed);
			hosc_q <= hosc_clk;
			pcnt <= osc_enable ? 0 : pcnt + 1;
			hcnt <= !osc_enable ? 0 : hcnt + int'(hosc_clk && !hosc_q);
		end
	end
	////////////////////////////////////////////////////////////////////////
	vector_zero_a: assert property (reset_vector == RESET_VECTOR)
		else $error("reset vector not zero");
	power_wait_a: assert property ($rose(osc_enable) |-> pcnt >= POWER_CYCLES)
		else $error("oscillator started before power wait");
	clock_load_a: assert property ($rose(sys_reset_n) |-> clock_source_sel == clock_source_cfg)
		else $error("clock selection not loaded");
	warmup_count_a: assert property ($rose(sys_reset_n) |-> hcnt >= HOSC_WARMUP_PERIODS)
		else $error("released before fast clock warm-up");
	pin_direct_a: assert property (pin_mode == PIN_RESET_DIRECT && $fell(reset_pin_n)
		|-> ##[1:6] !sys_reset_n) else $error("direct pin reset late");
	high_volt_a: assert property ((detect_level == DETECT_LEVEL_HIGH && vdd_below_2v4)[*5]
		|-> !sys_reset_n) else $error("no reset below 2.4 V");
	soft_reset_a: assert property (soft_req |-> ##[1:3] !sys_reset_n)
		else $error("second request gave no reset");
	soft_osc_a: assert property (soft_req |=> osc_enable[*8])
		else $error("software reset stopped oscillator");
	clear_read_a: assert property (sfr_rd && sfr_addr == REG_WDCLR_ADDR |=> sfr_rdata == 8'h00)
		else $error("clear register readable");
endmodule : rpoc_ctrl_checker

// *** verif/rpoc_analog_model.sv ***
// Model of supply detectors, reset pin and oscillators
`timescale 1ns/1ps
module rpoc_analog_model #(
	parameter int HOSC_NS = 21,
	parameter int ILRC_NS = 40
) (
	input wire logic [1:0] supply_code,
	input wire logic pin_low,
	input wire logic osc_enable,
	output logic vdd_below_1v8,
	output logic vdd_below_2v4,
	output logic vdd_below_3v3,
	output logic reset_pin_n,
	output logic ilrc_clk,
	output logic hosc_clk
);
	// Nested detectors: a lower threshold implies the higher ones
	assign vdd_below_3v3 = supply_code >= 2'h1;
	assign vdd_below_2v4 = supply_code >= 2'h2;
	assign vdd_below_1v8 = supply_code == 2'h3;
	// Pin has a pull-up, so released means high
	assign reset_pin_n = !pin_low;
	initial begin
		ilrc_clk = 1'b0;
		forever #(ILRC_NS / 2.0) ilrc_clk = !ilrc_clk;
	end
	// Fast source stands still until started
	initial begin
		hosc_clk = 1'b0;
		forever begin
			#(HOSC_NS / 2.0);
			hosc_clk = osc_enable ? !hosc_clk : 1'b0;
		end
	end
endmodule : rpoc_analog_model

// *** verif/tb.sv ***
// Self-checking testbench of the reset and power-on controller
`timescale 1ns/1ps
module tb;
	import rpoc_pkg::*;
	localparam int PWR = 20;
	localparam int DEB = 10;
	localparam int ILRC_NS = 40;
	logic ref_clk, rstn, pin_low, osc_enable, sys_reset_n, shared_reset_port_bit;
	logic reset_pin_n, vdd_below_1v8, vdd_below_2v4, vdd_below_3v3, ilrc_clk, hosc_clk;
	logic [1:0] supply_code, detect_level, pin_mode, wdt_mode, wdt_prescale, cpu_mode;
	logic [2:0] clock_source_cfg, clock_source_sel;
	logic sfr_wr, sfr_rd;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
	logic [15:0] reset_vector;
	int num_errors, n_checks;
	rpoc_ctrl #(.POWER_CYCLES(PWR), .DEBOUNCE_LOW_CYCLES(DEB)) u_rpoc_ctrl (.*);
	rpoc_analog_model #(.ILRC_NS(ILRC_NS)) u_rpoc_analog_model (.*);
	////////////////////////////////////////////////////////////////////////
	function automatic int wdt_cycles(input int p);
		return 256 * (4 << p) * ILRC_NS / 5;
	endfunction : wdt_cycles
	function automatic logic [7:0] flags_exp(input logic [1:0] lvl, input logic [7:0] c);
		return c | (lvl == DETECT_LEVEL_MEDIUM && supply_code >= 2'h2 ? 8'h04 : 8'h00)
			| (lvl == DETECT_LEVEL_HIGH && supply_code >= 2'h1 ? 8'h02 : 8'h00);
	endfunction : flags_exp
	task automatic check_val(input string name, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", name, e, g);
		end
	endtask : check_val
	task automatic check_bit(input string name, input logic e, input logic g);
		check_val(name, {15'h0, e}, {15'h0, g});
	endtask : check_bit
	task automatic tick(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : tick
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		sfr_wr = 1'b1;
		sfr_addr = a;
		sfr_wdata = d;
		@(negedge ref_clk);
		sfr_wr = 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge ref_clk);
		sfr_rd = 1'b1;
		sfr_addr = a;
		@(negedge ref_clk);
		sfr_rd = 1'b0;
		@(negedge ref_clk);
		check_val($sformatf("read of %h", a), {8'h00, e}, {8'h00, sfr_rdata});
	endtask : rd
	// Bounded wait for a reset level, with the cycles it took
	task automatic wait_sys(input logic lvl, input int lim, output int n);
		n = 0;
		while (sys_reset_n !== lvl && n < lim) begin
			@(negedge ref_clk);
			n++;
		end
		check_bit("reset level", lvl, sys_reset_n);
	endtask : wait_sys
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : wrap_up
	////////////////////////////////////////////////////////////////////////
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = !ref_clk;
	end
	// Whole run is about 80k cycles; limit keeps it under 100k
	initial begin
		#(100000 * 5);
		num_errors++;
		wrap_up();
	end
	initial begin
		int n;
		int w;
		rstn = 1'b0;
		pin_low = 1'b0;
		supply_code = 2'h0;
		detect_level = DETECT_LEVEL_LOWEST;
		pin_mode = PIN_PORT_BIT;
		wdt_mode = WDT_MODE_DISABLE;
		wdt_prescale = 2'h0;
		cpu_mode = CPU_NORMAL;
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		sfr_addr = 8'h00;
		sfr_wdata = 8'h00;
		num_errors = 0;
		n_checks = 0;
		void'($urandom(32'h22f2));
		clock_source_cfg = 3'($urandom);
		tick(2);
		rstn = 1'b1;
		wait_sys(1'b1, 12000, n);
		check_bit("warm-up length", 1'b1, n > PWR + 2048 * 21 / 5);
		check_val("clock select", {13'h0, clock_source_cfg}, {13'h0, clock_source_sel});
		check_val("vector", RESET_VECTOR, reset_vector);
		rd(REG_CAUSE_ADDR, 8'h00);
		pin_low = 1'b1;
		tick(8);
		check_bit("port bit low", 1'b0, shared_reset_port_bit);
		check_bit("port mode reset", 1'b1, sys_reset_n);
		pin_low = 1'b0;
		tick(4);
		check_bit("port bit high", 1'b1, shared_reset_port_bit);
		$display("test power_on done");
		wr(REG_SWRST_ADDR, 8'h01);
		rd(REG_SWRST_ADDR, 8'h01);
		w = $urandom_range(255, 0);
		if (w == int'(WDT_CLEAR_KEY)) w = 0;
		wr(REG_WDCLR_ADDR, 8'(w));
		wr(REG_SWRST_ADDR, 8'h01);
		check_bit("broken pair", 1'b1, sys_reset_n);
		wr(REG_SWRST_ADDR, 8'h01);
		tick(1);
		check_bit("soft reset", 1'b0, sys_reset_n);
		check_bit("osc kept", 1'b1, osc_enable);
		wait_sys(1'b1, 20, n);
		wr(REG_CAUSE_ADDR, 8'(~w));
		rd(REG_CAUSE_ADDR, 8'h00);
		rd(REG_WDCLR_ADDR, 8'h00);
		rd(8'h40, 8'h00);
		$display("test software done");
		wdt_mode = WDT_MODE_ENABLE;
		cpu_mode = $urandom_range(1, 0) ? CPU_IDLE : CPU_STOP;
		tick(9000);
		check_bit("idle hold", 1'b1, sys_reset_n);
		wdt_mode = WDT_MODE_ALWAYS;
		wr(REG_WDCLR_ADDR, WDT_CLEAR_KEY);
		tick($urandom_range(wdt_cycles(0) - 500, 2000));
		wr(REG_WDCLR_ADDR, WDT_CLEAR_KEY);
		wait_sys(1'b0, wdt_cycles(0) + 100, n);
		check_bit("watchdog period", 1'b1, n > wdt_cycles(0) - 40 && n < wdt_cycles(0) + 40);
		wdt_mode = WDT_MODE_DISABLE;
		cpu_mode = CPU_NORMAL;
		wait_sys(1'b1, 12000, n);
		rd(REG_CAUSE_ADDR, 8'h40);
		$display("test watchdog done");
		pin_mode = PIN_RESET_DIRECT;
		pin_low = 1'b1;
		tick(6);
		check_bit("pin reset", 1'b0, sys_reset_n);
		tick($urandom_range(60, 20));
		check_bit("pin held", 1'b0, sys_reset_n);
		pin_low = 1'b0;
		wait_sys(1'b1, 12000, n);
		rd(REG_CAUSE_ADDR, 8'h20);
		pin_mode = PIN_RESET_DEBOUNCE;
		pin_low = 1'b1;
		tick(DEB - 4);
		pin_low = 1'b0;
		tick(8);
		check_bit("short pulse", 1'b1, sys_reset_n);
		pin_low = 1'b1;
		tick(DEB + 8);
		check_bit("long pulse", 1'b0, sys_reset_n);
		pin_low = 1'b0;
		wait_sys(1'b1, 12000, n);
		pin_mode = PIN_PORT_BIT;
		$display("test pin done");
		supply_code = 2'h2;
		for (int i = 0; i < 2; i++) begin
			detect_level = 2'(i);
			tick(8);
			check_bit("no supply reset", 1'b1, sys_reset_n);
			rd(REG_CAUSE_ADDR, flags_exp(2'(i), 8'h20));
		end
		detect_level = DETECT_LEVEL_HIGH;
		tick(8);
		check_bit("high level reset", 1'b0, sys_reset_n);
		supply_code = 2'h1;
		wait_sys(1'b1, 12000, n);
		rd(REG_CAUSE_ADDR, flags_exp(DETECT_LEVEL_HIGH, 8'h80));
		detect_level = DETECT_LEVEL_MAXIMUM;
		tick(8);
		check_bit("maximum level reset", 1'b0, sys_reset_n);
		supply_code = 2'h0;
		wait_sys(1'b1, 12000, n);
		rd(REG_CAUSE_ADDR, 8'h80);
		$display("test supply done");
		wrap_up();
	end
endmodule : tb

bind rpoc_ctrl rpoc_ctrl_checker #(
	.POWER_CYCLES(POWER_CYCLES),
	.DEBOUNCE_LOW_CYCLES(DEBOUNCE_LOW_CYCLES)
) u_rpoc_ctrl_checker (.*);
